// file: rtl/lcdirq_consts.svh
// Constants for the display interrupt, test-mux and ident block.
// Included by the package users; definitions only.
`ifndef LCDIRQ_CONSTS_SVH
`define LCDIRQ_CONSTS_SVH
`define LCDIRQ_OFF_MASK    12'h018
`define LCDIRQ_OFF_RAW     12'h01C
`define LCDIRQ_OFF_MSTAT   12'h020
`define LCDIRQ_OFF_CLEAR   12'h024
`define LCDIRQ_OFF_CTRL    12'h028
`define LCDIRQ_OFF_TCR     12'hF00
`define LCDIRQ_OFF_ITOP1   12'hF04
`define LCDIRQ_OFF_ITOP2   12'hF08
`define LCDIRQ_OFF_PID0    12'hFE0
`define LCDIRQ_OFF_PID1    12'hFE4
`define LCDIRQ_OFF_PID2    12'hFE8
`define LCDIRQ_OFF_PID3    12'hFEC
`define LCDIRQ_OFF_CID0    12'hFF0
`define LCDIRQ_OFF_CID1    12'hFF4
`define LCDIRQ_OFF_CID2    12'hFF8
`define LCDIRQ_OFF_CID3    12'hFFC
// Interrupt bit positions
`define LCDIRQ_BIT_FUF     0
`define LCDIRQ_BIT_BASE    1
`define LCDIRQ_BIT_VCMP    2
`define LCDIRQ_BIT_BERR    3
// Control register fields
`define LCDIRQ_CTRL_TIMING_CLOCK_SELECT_BIT 2
// Test output 1 fields
`define LCDIRQ_T1_TIMING_CLOCK_SELECT_BIT   5
`define LCDIRQ_T1_BERR     4
`define LCDIRQ_T1_FUF      3
`define LCDIRQ_T1_BASE     2
`define LCDIRQ_T1_VCMP     1
`define LCDIRQ_T1_COMB     0
// Test output 2 fields, then the test control enable bit
`define LCDIRQ_T2_POWER    29
`define LCDIRQ_T2_LP       28
`define LCDIRQ_T2_CP       27
`define LCDIRQ_T2_FP       26
`define LCDIRQ_T2_AC       25
`define LCDIRQ_T2_LE       24
`define LCDIRQ_TCR_INTEGRATION_TEST_ENABLE    0
// Reset values
`define LCDIRQ_RST_TCR     1'h0
`define LCDIRQ_RST_ITOP1   6'h00
`define LCDIRQ_RST_ITOP2   30'h0000_0000
`define LCDIRQ_RST_MASK    4'h0
`define LCDIRQ_RST_CTRL    3'h0
// Ident fields; part, designer and cell word values are arbitrary
`define LCDIRQ_ID_PART     12'h5A3
`define LCDIRQ_ID_DESIGNER 8'h7C
`define LCDIRQ_ID_REVISION 4'h0
`define LCDIRQ_ID_CONFIG   8'h00
`define LCDIRQ_CID_WORD    32'h1234_5678
`endif

// file: rtl/lcdirq_pkg.sv
// Types for the display interrupt, test-mux and identification block.
// Assumes lcdirq_consts.svh sits in the include path.
package lcdirq_pkg;
  typedef enum logic [1:0] {
    LCDIRQ_VS_SYNC,
    LCDIRQ_VS_BACK,
    LCDIRQ_VS_ACTIVE,
    LCDIRQ_VS_FRONT
  } lcdirq_vregion_type;

  typedef enum {
    LCDIRQ_MB_FETCH,
    LCDIRQ_MB_ERROR
  } lcdirq_mstate_type;
endpackage

// file: rtl/lcdirq_flag.sv
// One sticky event flag: set by a hardware strobe, cleared by software.
// Assumes the strobe and clear are synchronous to ref_clk_i.
module lcdirq_flag (
  input  wire logic ref_clk_i,  // Bus clock
  input  wire logic sys_rst_i,  // Async reset, active high
  input  wire logic set_i,      // Event strobe
  input  wire logic clr_i,      // Software clear strobe
  input  wire logic mask_i,     // Enable for the masked output
  output logic      raw_o,      // Sticky raw status
  output logic      irq_o       // Raw ANDed with mask
);
  logic flag_r;

  // Set wins so an event in the clear cycle is kept
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_r <= 1'b0;
    end else if (set_i) begin
      flag_r <= 1'b1;
    end else if (clr_i) begin
      flag_r <= 1'b0;
    end
  end

  assign raw_o = flag_r;
  assign irq_o = flag_r & mask_i;
endmodule // lcdirq_flag

// file: rtl/lcdirq_bus_master_state.sv
// Fetch-permission state of the frame bus master after an error.
// Assumes the error strobe comes from the master port's response decode.
module lcdirq_bus_master_state
  import lcdirq_pkg::*;
(
  input  wire logic ref_clk_i,      // Bus clock
  input  wire logic sys_rst_i,      // Async reset, active high
  input  wire logic bus_err_i,      // Error response seen
  input  wire logic err_clr_i,      // Software bus error clear
  output logic      fetch_en_o,     // Frame fetches allowed
  output logic      frame_restart_o // Pulse: restart at frame start
);
  lcdirq_mstate_type state_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= LCDIRQ_MB_FETCH;
    end else begin
      case (state_r)
        LCDIRQ_MB_FETCH: if (bus_err_i) state_r <= LCDIRQ_MB_ERROR;
        LCDIRQ_MB_ERROR: if (err_clr_i && !bus_err_i) state_r <= LCDIRQ_MB_FETCH;
        default: state_r <= LCDIRQ_MB_FETCH;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_restart_o <= 1'b0;
    end else begin
      frame_restart_o <= (state_r == LCDIRQ_MB_ERROR) && err_clr_i && !bus_err_i;
    end
  end

  assign fetch_en_o = (state_r == LCDIRQ_MB_FETCH) && !bus_err_i;
endmodule // lcdirq_bus_master_state

// file: rtl/lcdirq_top.sv
// Interrupt generation, integration-test output muxes and ident registers.
// Assumes event strobes and functional pad values are synchronous to ref_clk_i.
`include "lcdirq_consts.svh"

module lcdirq_top
  import lcdirq_pkg::*;
(
  input  wire logic        ref_clk_i,              // Bus clock, 100 MHz
  input  wire logic        sys_rst_i,              // Async reset, active high
  input  wire logic [11:0] s_axi_awaddr_i,         // Write address
  input  wire logic        s_axi_awvalid_i,        // Write address valid
  output logic             s_axi_awready_o,        // Write address ready
  input  wire logic [31:0] s_axi_wdata_i,          // Write data
  input  wire logic [3:0]  s_axi_wstrb_i,          // Write byte strobes
  input  wire logic        s_axi_wvalid_i,         // Write data valid
  output logic             s_axi_wready_o,         // Write data ready
  output logic [1:0]       s_axi_bresp_o,          // Write response
  output logic             s_axi_bvalid_o,         // Write response valid
  input  wire logic        s_axi_bready_i,         // Write response ready
  input  wire logic [11:0] s_axi_araddr_i,         // Read address
  input  wire logic        s_axi_arvalid_i,        // Read address valid
  output logic             s_axi_arready_o,        // Read address ready
  output logic [31:0]      s_axi_rdata_o,          // Read data
  output logic [1:0]       s_axi_rresp_o,          // Read response
  output logic             s_axi_rvalid_o,         // Read data valid
  input  wire logic        s_axi_rready_i,         // Read data ready
  input  wire logic        master_err_resp_i,      // Master got ERROR
  input  wire logic        base_copy_upper_i,      // Upper base copied
  input  wire logic        base_copy_lower_i,      // Lower base copied
  input  wire logic        fifo_underflow_upper_i, // Upper FIFO underflow
  input  wire logic        fifo_underflow_lower_i, // Lower FIFO underflow
  input  wire logic        vsync_start_i,          // Sync region starts
  input  wire logic        vback_start_i,          // Back porch starts
  input  wire logic        vactive_start_i,        // Active video starts
  input  wire logic        vfront_start_i,         // Front porch starts
  input  wire logic        scan_shift_enable_i,    // Scan test enable
  input  wire logic        func_power_i,           // Func power enable
  input  wire logic        func_line_i,            // Func line pulse
  input  wire logic        func_pclk_i,            // Func panel clock
  input  wire logic        func_frame_i,           // Func frame pulse
  input  wire logic        func_bias_i,            // Func bias/data enable
  input  wire logic        func_lend_i,            // Func line end
  input  wire logic [23:0] func_pixel_i,           // Func pixel data
  output logic             fetch_enable_o,         // Master may fetch frames
  output logic             frame_restart_o,        // Pulse: start fresh frame
  output logic             fifo_bypass_o,          // FIFOs bypassed in scan
  output logic             bus_error_irq_o,        // Master bus error interrupt
  output logic             vertical_compare_irq_o, // Vertical compare interrupt
  output logic             base_update_irq_o,      // Base update interrupt
  output logic             fifo_underflow_irq_o,   // Underflow interrupt
  output logic             combined_irq_o,         // Combined interrupt
  output logic             ref_clock_select_out_o, // Reference clock select
  output logic             panel_power_enable_o,   // Pad: power enable
  output logic             line_pulse_o,           // Pad: line pulse
  output logic             panel_clock_o,          // Pad: panel clock
  output logic             frame_pulse_o,          // Pad: frame pulse
  output logic             bias_or_data_enable_o,  // Pad: bias/data enable
  output logic             line_end_o,             // Pad: line end
  output logic [23:0]      panel_pixel_data_o      // Pad: pixel data
);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic [3:0]  irq_mask_reg_r;
  logic [2:0]  ctrl_r;
  logic        tcr_r;
  logic [5:0]  itop1_r;
  logic [29:0] itop2_r;
  logic [3:0]  raw_irq;
  logic [3:0]  mirq;
  logic [3:0]  set_ev;
  logic [3:0]  clr_ev;
  logic        test_en;
  logic [5:0]  onchip_mux;
  logic [31:0] periph_id;

  // Write capture; address and data in either order
  logic [11:0] wa_r;
  logic        wa_have_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        wd_have_r;
  logic        wr_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_val;

  assign s_axi_awready_o = !wa_have_r && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !wd_have_r && !s_axi_bvalid_o;
  assign wr_fire         = wa_have_r && wd_have_r && !s_axi_bvalid_o;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wa_have_r <= 1'b0;
      wa_r      <= 12'h000;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      wa_have_r <= 1'b1;
      wa_r      <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      wa_have_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wd_have_r <= 1'b0;
      wd_r      <= 32'h0000_0000;
      ws_r      <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      wd_have_r <= 1'b1;
      wd_r      <= s_axi_wdata_i;
      ws_r      <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      wd_have_r <= 1'b0;
    end
  end

  // Write enables, live only on the firing cycle; wr_ro flags read-only addresses ungated
  logic we_mask;
  logic we_ctrl;
  logic we_clear;
  logic we_tcr;
  logic we_itop1;
  logic we_itop2;
  logic wr_ro;

  always_comb begin
    we_mask  = 1'b0;
    we_ctrl  = 1'b0;
    we_clear = 1'b0;
    we_tcr   = 1'b0;
    we_itop1 = 1'b0;
    we_itop2 = 1'b0;
    wr_ro    = 1'b0;
    if (wa_r[11:2] == `LCDIRQ_OFF_MASK >> 2) begin
      we_mask = wr_fire;
    end else if (wa_r[11:2] == `LCDIRQ_OFF_CTRL >> 2) begin
      we_ctrl = wr_fire;
    end else if (wa_r[11:2] == `LCDIRQ_OFF_CLEAR >> 2) begin
      we_clear = wr_fire;
    end else if (wa_r[11:2] == `LCDIRQ_OFF_TCR >> 2) begin
      we_tcr = wr_fire;
    end else if (wa_r[11:2] == `LCDIRQ_OFF_ITOP1 >> 2) begin
      we_itop1 = wr_fire;
    end else if (wa_r[11:2] == `LCDIRQ_OFF_ITOP2 >> 2) begin
      we_itop2 = wr_fire;
    end else if (wa_r[11:2] == `LCDIRQ_OFF_RAW >> 2 || wa_r[11:2] == `LCDIRQ_OFF_MSTAT >> 2 ||
                 wa_r[11:4] == `LCDIRQ_OFF_PID0 >> 4 || wa_r[11:4] == `LCDIRQ_OFF_CID0 >> 4) begin
      wr_ro = 1'b1;
    end
  end
  assign wr_hit = we_mask | we_ctrl | we_clear | we_tcr | we_itop1 | we_itop2 | wr_ro;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Lane 0 strobe gates the narrow registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_mask_reg_r <= `LCDIRQ_RST_MASK;
    end else if (we_mask && ws_r[0]) begin
      irq_mask_reg_r <= wd_r[3:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= `LCDIRQ_RST_CTRL;
    end else if (we_ctrl && ws_r[0]) begin
      ctrl_r <= wd_r[2:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tcr_r <= `LCDIRQ_RST_TCR;
    end else if (we_tcr && ws_r[0]) begin
      tcr_r <= wd_r[`LCDIRQ_TCR_INTEGRATION_TEST_ENABLE];
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      itop1_r <= `LCDIRQ_RST_ITOP1;
    end else if (we_itop1 && ws_r[0]) begin
      itop1_r <= wd_r[5:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      itop2_r <= `LCDIRQ_RST_ITOP2;
    end else if (we_itop2) begin
      for (int b = 0; b < 4; b++) begin
        if (ws_r[b]) begin
          for (int k = 0; k < 8; k++) begin
            if (b * 8 + k < 30) begin
              itop2_r[b * 8 + k] <= wd_r[b * 8 + k];
            end
          end
        end
      end
    end
  end

  // Event sources
  lcdirq_vregion_type vsel;
  logic               vcmp_ev;
  assign vsel = lcdirq_vregion_type'(ctrl_r[1:0]);

  always_comb begin
    case (vsel)
      LCDIRQ_VS_SYNC:   vcmp_ev = vsync_start_i;
      LCDIRQ_VS_BACK:   vcmp_ev = vback_start_i;
      LCDIRQ_VS_ACTIVE: vcmp_ev = vactive_start_i;
      default:          vcmp_ev = vfront_start_i;
    endcase
  end

  assign set_ev[`LCDIRQ_BIT_BERR] = master_err_resp_i;
  assign set_ev[`LCDIRQ_BIT_VCMP] = vcmp_ev;
  assign set_ev[`LCDIRQ_BIT_BASE] = base_copy_upper_i | base_copy_lower_i;
  assign set_ev[`LCDIRQ_BIT_FUF]  = fifo_underflow_upper_i | fifo_underflow_lower_i;
  // Write-one-to-clear, zero bits leave flags alone
  assign clr_ev = (we_clear && ws_r[0]) ? wd_r[3:0] : 4'h0;

  for (genvar g = 0; g < 4; g++) begin : g_flag
    lcdirq_flag u_flag (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .set_i     (set_ev[g]),
      .clr_i     (clr_ev[g]),
      .mask_i    (irq_mask_reg_r[g]),
      .raw_o     (raw_irq[g]),
      .irq_o     (mirq[g])
    );
  end

  lcdirq_bus_master_state u_mstate (
    .ref_clk_i       (ref_clk_i),
    .sys_rst_i       (sys_rst_i),
    .bus_err_i       (master_err_resp_i),
    .err_clr_i       (clr_ev[`LCDIRQ_BIT_BERR]),
    .fetch_en_o      (fetch_enable_o),
    .frame_restart_o (frame_restart_o)
  );

  // Scan bypass relies on the tester holding this low in service
  assign fifo_bypass_o = scan_shift_enable_i;

  // Test multiplexers
  assign test_en = tcr_r;
  always_comb begin
    if (test_en) begin
      onchip_mux = itop1_r;
    end else begin
      onchip_mux[`LCDIRQ_T1_TIMING_CLOCK_SELECT_BIT] = ctrl_r[`LCDIRQ_CTRL_TIMING_CLOCK_SELECT_BIT];
      onchip_mux[`LCDIRQ_T1_BERR]   = mirq[`LCDIRQ_BIT_BERR];
      onchip_mux[`LCDIRQ_T1_FUF]    = mirq[`LCDIRQ_BIT_FUF];
      onchip_mux[`LCDIRQ_T1_BASE]   = mirq[`LCDIRQ_BIT_BASE];
      onchip_mux[`LCDIRQ_T1_VCMP]   = mirq[`LCDIRQ_BIT_VCMP];
      onchip_mux[`LCDIRQ_T1_COMB]   = |mirq;
    end
  end

  assign ref_clock_select_out_o = onchip_mux[`LCDIRQ_T1_TIMING_CLOCK_SELECT_BIT];
  assign bus_error_irq_o        = onchip_mux[`LCDIRQ_T1_BERR];
  assign fifo_underflow_irq_o   = onchip_mux[`LCDIRQ_T1_FUF];
  assign base_update_irq_o      = onchip_mux[`LCDIRQ_T1_BASE];
  assign vertical_compare_irq_o = onchip_mux[`LCDIRQ_T1_VCMP];
  assign combined_irq_o         = onchip_mux[`LCDIRQ_T1_COMB];

  // Pad mux; functional values pass through in normal mode
  assign panel_power_enable_o  = test_en ? itop2_r[`LCDIRQ_T2_POWER] : func_power_i;
  assign line_pulse_o          = test_en ? itop2_r[`LCDIRQ_T2_LP]    : func_line_i;
  assign panel_clock_o         = test_en ? itop2_r[`LCDIRQ_T2_CP]    : func_pclk_i;
  assign frame_pulse_o         = test_en ? itop2_r[`LCDIRQ_T2_FP]    : func_frame_i;
  assign bias_or_data_enable_o = test_en ? itop2_r[`LCDIRQ_T2_AC]    : func_bias_i;
  assign line_end_o            = test_en ? itop2_r[`LCDIRQ_T2_LE]    : func_lend_i;
  assign panel_pixel_data_o    = test_en ? itop2_r[23:0]             : func_pixel_i;

  assign periph_id = {`LCDIRQ_ID_CONFIG, `LCDIRQ_ID_REVISION, `LCDIRQ_ID_DESIGNER, `LCDIRQ_ID_PART};

  // Read decode; ident bytes sit in bits 7:0, upper bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr_i[11:2] == `LCDIRQ_OFF_MASK >> 2) begin
      rd_val[3:0] = irq_mask_reg_r;
    end else if (s_axi_araddr_i[11:2] == `LCDIRQ_OFF_RAW >> 2) begin
      rd_val[3:0] = raw_irq;
    end else if (s_axi_araddr_i[11:2] == `LCDIRQ_OFF_MSTAT >> 2) begin
      rd_val[3:0] = mirq;
    end else if (s_axi_araddr_i[11:2] == `LCDIRQ_OFF_CLEAR >> 2) begin
      rd_val = 32'h0000_0000;
    end else if (s_axi_araddr_i[11:2] == `LCDIRQ_OFF_CTRL >> 2) begin
      rd_val[2:0] = ctrl_r;
    end else if (s_axi_araddr_i[11:2] == `LCDIRQ_OFF_TCR >> 2) begin
      rd_val[0] = tcr_r;
    end else if (s_axi_araddr_i[11:2] == `LCDIRQ_OFF_ITOP1 >> 2) begin
      rd_val[5:0] = onchip_mux;
    end else if (s_axi_araddr_i[11:2] == `LCDIRQ_OFF_ITOP2 >> 2) begin
      rd_val[29:0] = itop2_r;
    end else if (s_axi_araddr_i[11:4] == `LCDIRQ_OFF_PID0 >> 4) begin
      rd_val[7:0] = periph_id[s_axi_araddr_i[3:2] * 8 +: 8];
    end else if (s_axi_araddr_i[11:4] == `LCDIRQ_OFF_CID0 >> 4) begin
      rd_val[7:0] = 8'(`LCDIRQ_CID_WORD >> (s_axi_araddr_i[3:2] * 8));
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_val;
      s_axi_rresp_o  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule // lcdirq_top

// file: testbench/lcdirq_top_monitor.sv
// Checker for the interrupt and test-mux block, watching its ports only.
// Assumes a bind onto lcdirq_top; test mode is mirrored from bus writes.
module lcdirq_monitor (
  input wire logic        ref_clk_i,              // Clock
  input wire logic        sys_rst_i,              // Reset
  input wire logic [11:0] s_axi_awaddr_i,         // AW addr
  input wire logic        s_axi_awvalid_i,        // AW valid
  input wire logic        s_axi_awready_o,        // AW ready
  input wire logic [31:0] s_axi_wdata_i,          // W data
  input wire logic        s_axi_wvalid_i,         // W valid
  input wire logic        s_axi_wready_o,         // W ready
  input wire logic        s_axi_bvalid_o,         // B valid
  input wire logic        master_err_resp_i,      // Error
  input wire logic        fifo_underflow_upper_i, // Upper uf
  input wire logic        fifo_underflow_lower_i, // Lower uf
  input wire logic        fetch_enable_o,         // Fetch
  input wire logic        frame_restart_o,        // Restart
  input wire logic        bus_error_irq_o,        // Irq
  input wire logic        vertical_compare_irq_o, // Irq
  input wire logic        base_update_irq_o,      // Irq
  input wire logic        fifo_underflow_irq_o,   // Irq
  input wire logic        combined_irq_o          // Irq
);
  logic [11:0] a_r;
  logic        d_r, bv_r, tm_r, tm_w;
  // New test mode is live from the edge the write response rises
  assign tm_w = (s_axi_bvalid_o && !bv_r && a_r == 12'hF00) ? d_r : tm_r;
  always_ff @(posedge ref_clk_i) if (s_axi_awvalid_i && s_axi_awready_o) a_r <= s_axi_awaddr_i;
  always_ff @(posedge ref_clk_i) if (s_axi_wvalid_i && s_axi_wready_o) d_r <= s_axi_wdata_i[0];
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bv_r <= 1'b0;
      tm_r <= 1'b0;
    end else begin
      bv_r <= s_axi_bvalid_o;
      tm_r <= tm_w;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  comb_or_a: assert property (!tm_w |-> combined_irq_o == (bus_error_irq_o || vertical_compare_irq_o ||
    base_update_irq_o || fifo_underflow_irq_o)) else $error("combined irq mismatch");
  ber_sticky_a: assert property (!tm_w && bus_error_irq_o |=> bus_error_irq_o || $rose(s_axi_bvalid_o))
    else $error("bus error irq dropped");
  fuf_sticky_a: assert property (!tm_w && fifo_underflow_irq_o |=> fifo_underflow_irq_o || $rose(s_axi_bvalid_o))
    else $error("underflow irq dropped");
  err_stop_a: assert property (master_err_resp_i |-> !fetch_enable_o ##1 !fetch_enable_o)
    else $error("fetch after error");
  err_hold_a: assert property (!fetch_enable_o |=> !fetch_enable_o || $rose(s_axi_bvalid_o))
    else $error("error state left early");
  restart_a: assert property ($rose(fetch_enable_o) |-> ##[0:2] frame_restart_o)
    else $error("no frame restart");
  restart_cause_a: assert property (frame_restart_o |-> !$past(fetch_enable_o) || !$past(fetch_enable_o, 2))
    else $error("restart without error");
  fuf_rise_a: assert property (!tm_w && $rose(fifo_underflow_irq_o) |-> $past(fifo_underflow_upper_i) ||
    $past(fifo_underflow_lower_i) || $rose(s_axi_bvalid_o)) else $error("underflow irq without cause");
endmodule // lcdirq_monitor

bind lcdirq_top lcdirq_monitor u_mon (.*);

// file: testbench/lcdirq_intc_model.sv
// Stand-in for the system interrupt and test controllers.
// Assumes clock and combined interrupt from the bench.
module lcdirq_intc_model (
  input  wire logic ref_clk_i,  // Bus clock
  input  wire logic sys_rst_i,  // Async reset
  input  wire logic irq_i,      // Combined interrupt
  input  wire logic scan_req_i, // Bench asks for scan test
  output logic      scan_o,     // Scan enable to the block
  output int        edges_o     // Interrupt rising edges seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_r;
  assign scan_o = scan_req_i;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_r <= 1'b0;
      edges_o <= 0;
    end else begin
      irq_r <= irq_i;
      if (irq_i && !irq_r) edges_o <= edges_o + 1;
    end
  end
endmodule // lcdirq_intc_model

// file: testbench/lcdirq_top_tb.sv
// Bench for lcdirq_top: bus tasks, pulses, scenario tasks.
// Assumes lcdirq_consts.svh in the include path and the monitor bound.
`include "lcdirq_consts.svh"
module lcdirq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, sys_rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, scan_req = 0;
  logic [11:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, d;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [1:0] r;
  logic [8:0] ev = 0;
  logic [29:0] fp = 30'h2C3A_5A5A;
  int n_mismatch = 0, total_checks = 0, n_rst = 0, cyc = 0, edges;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, fetch_enable_o;
  wire frame_restart_o, fifo_bypass_o, bus_error_irq_o, vertical_compare_irq_o, base_update_irq_o;
  wire fifo_underflow_irq_o, combined_irq_o, ref_clock_select_out_o, panel_power_enable_o, line_pulse_o;
  wire panel_clock_o, frame_pulse_o, bias_or_data_enable_o, line_end_o, scan_shift_enable_i;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire [23:0] panel_pixel_data_o, func_pixel_i;
  wire master_err_resp_i, base_copy_upper_i, base_copy_lower_i, fifo_underflow_upper_i, fifo_underflow_lower_i;
  wire vsync_start_i, vback_start_i, vactive_start_i, vfront_start_i;
  wire func_power_i, func_line_i, func_pclk_i, func_frame_i, func_bias_i, func_lend_i;
  assign {vfront_start_i, vactive_start_i, vback_start_i, vsync_start_i, fifo_underflow_lower_i,
          fifo_underflow_upper_i, base_copy_lower_i, base_copy_upper_i, master_err_resp_i} = ev;
  assign {func_power_i, func_line_i, func_pclk_i, func_frame_i, func_bias_i, func_lend_i, func_pixel_i} = fp;
  wire [29:0] pads = {panel_power_enable_o, line_pulse_o, panel_clock_o, frame_pulse_o, bias_or_data_enable_o,
                      line_end_o, panel_pixel_data_o};
  wire [5:0] onc = {ref_clock_select_out_o, bus_error_irq_o, fifo_underflow_irq_o, base_update_irq_o,
                    vertical_compare_irq_o, combined_irq_o};
  wire [3:0] irqv = {bus_error_irq_o, vertical_compare_irq_o, base_update_irq_o, fifo_underflow_irq_o};
  lcdirq_top DUT (.*);
  lcdirq_intc_model u_intc (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .irq_i(combined_irq_o),
                            .scan_req_i(scan_req), .scan_o(scan_shift_enable_i), .edges_o(edges));
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (frame_restart_o === 1'b1) n_rst++;
    // Tests need about 250 cycles
    if (++cyc == 5000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    fork
      begin do @(posedge ref_clk_i); while (s_axi_awready_o !== 1'b1); s_axi_awvalid_i <= 0; end
      begin do @(posedge ref_clk_i); while (s_axi_wready_o !== 1'b1); s_axi_wvalid_i <= 0; end
    join
    while (s_axi_bvalid_o !== 1'b1) @(posedge ref_clk_i);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    do @(posedge ref_clk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 0;
    while (s_axi_rvalid_o !== 1'b1) @(posedge ref_clk_i);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk("read", d, e);
  endtask
  task automatic pulse(input logic [8:0] b);
    @(posedge ref_clk_i) ev <= b;
    @(posedge ref_clk_i) ev <= 0;
    @(posedge ref_clk_i);
  endtask
  task automatic t_test;
    rc(12'hF00, 0);
    rc(12'hF04, 0);
    rc(12'hF08, 0);
    wr(12'hF04, 32'h0000_002A);
    wr(12'hF08, 32'h2ABC_DEF0);
    chk("pads", 32'(pads), 32'(fp));
    wr(12'hF00, 1);
    chk("onchip", 32'(onc), 32'h0000_002A);
    rc(12'hF04, 32'h0000_002A);
    chk("tpads", 32'(pads), 32'h2ABC_DEF0);
    wr(12'hF00, 0);
    chk("pads", 32'(pads), 32'(fp));
    scan_req <= 1;
    @(posedge ref_clk_i);
    chk("scan", 32'(fifo_bypass_o), 1);
    scan_req <= 0;
    $display("test mode done");
  endtask
  task automatic t_ident;
    logic [31:0] p;
    p = {`LCDIRQ_ID_CONFIG, `LCDIRQ_ID_REVISION, `LCDIRQ_ID_DESIGNER, `LCDIRQ_ID_PART};
    for (int i = 0; i < 4; i++) begin
      rc(12'hFE0 + 12'(4 * i), {24'h0, p[8*i +: 8]});
      rc(12'hFF0 + 12'(4 * i), 32'(`LCDIRQ_CID_WORD >> (8 * i)) & 32'h0000_00FF);
    end
    wr(12'hFE0, 32'hFFFF_FFFF);
    chk("bresp", 32'(r), 0);
    rc(12'hFE0, {24'h0, p[7:0]});
    rd(12'h100);
    chk("resp", 32'(r), 2);
    $display("ident done");
  endtask
  task automatic t_irq;
    int rb[5] = '{3, 1, 1, 0, 0};
    logic [3:0] b;
    wr(12'h018, 32'h0000_000F);
    for (int i = 0; i < 5; i++) begin
      b = 4'(1 << rb[i]);
      pulse(9'(1 << i));
      rc(12'h01C, 32'(b));
      chk("irq", 32'({combined_irq_o, irqv}), 32'({1'b1, b}));
      if (i == 0) chk("fetch", 32'(fetch_enable_o), 0);
      wr(12'h024, 32'(b));
      chk("clear", 32'(irqv), 0);
    end
    chk("fetch", 32'(fetch_enable_o), 1);
    chk("restart", 32'(n_rst), 1);
    wr(12'h018, 0);
    pulse(9'h008);
    chk("mask", 32'(irqv), 0);
    rc(12'h01C, 1);
    wr(12'h018, 32'h0000_000F);
    chk("unmask", 32'(fifo_underflow_irq_o), 1);
    wr(12'h024, 1);
    for (int v = 0; v < 4; v++) begin
      wr(12'h028, 32'(v));
      pulse(9'h1E0 & ~(9'h020 << v));
      rc(12'h01C, 0);
      pulse(9'h020 << v);
      rc(12'h01C, 4);
      wr(12'h024, 4);
    end
    wr(12'h028, 4);
    chk("timing_clock_select_bit", 32'(ref_clock_select_out_o), 1);
    chk("edges", 32'(edges), 10);
    $display("interrupts done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    t_test;
    t_ident;
    t_irq;
    tally_and_finish;
  end
endmodule // lcdirq_top_tb
